/* File: core/acc_adc_ctrl.sv */
// module: converter configuration registers and conversion sequencer
`timescale 1ns/1ps
// Notes on behaviour
// - six-bit channel_select routes one source to sample-and-hold
// - two-bit pos_ref_select picks positive reference
// - one bit picks negative reference: pin or ground
// - conv_clock_select picks divide 2..64 or x11 rc clock
// - conversion takes 11.5 conversion clock periods
// - non-rc conversion clocks derive from system clock
module acc_adc_ctrl (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [5:0] channel_select,
  output logic [1:0] pos_ref_select,
  output logic neg_ref_ground,
  output logic [2:0] conv_clock_select,
  output logic rc_clock_enable,
  output logic converter_enable,
  output logic sample_hold,
  output logic conv_clock,
  output logic conv_busy,
  output logic conv_done
);
  // ==========================================================
  // bus decode
  logic wr_en;
  logic rd_en;
  logic hit;
  logic start_req;
  logic done_clr;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit = (paddr == acc_pkg::ADDR_CTRL_FIRST)
    || (paddr == acc_pkg::ADDR_CTRL_SECOND)
    || (paddr == acc_pkg::ADDR_STATUS);
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !hit;
  // a start write with enable set while idle launches a conversion
  assign start_req = wr_en && (paddr == acc_pkg::ADDR_CTRL_FIRST)
    && pwdata[acc_pkg::START_BIT] && pwdata[acc_pkg::ENABLE_BIT];
  // done is cleared by reading status
  assign done_clr = rd_en && (paddr == acc_pkg::ADDR_STATUS);

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      channel_select <= acc_pkg::CHAN_RESET;
      converter_enable <= 1'b0;
    end else if (wr_en && paddr == acc_pkg::ADDR_CTRL_FIRST) begin
      channel_select <= pwdata[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W];
      converter_enable <= pwdata[acc_pkg::ENABLE_BIT];
    end
  end

  // reference and clock selects
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_ref_select <= acc_pkg::PREF_RESET;
      neg_ref_ground <= 1'b0;
      conv_clock_select <= acc_pkg::CCS_RESET;
    end else if (wr_en && paddr == acc_pkg::ADDR_CTRL_SECOND) begin
      pos_ref_select <= pwdata[acc_pkg::PREF_LSB +: acc_pkg::PREF_W];
      neg_ref_ground <= pwdata[acc_pkg::NREF_BIT];
      conv_clock_select <= pwdata[acc_pkg::CCS_LSB +: acc_pkg::CCS_W];
    end
  end

  // rc oscillator runs only when selected, saves power otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rc_clock_enable <= 1'b0;
    end else begin
      rc_clock_enable <= (conv_clock_select[1:0] == acc_pkg::CCS_RC_LOW);
    end
  end

  // ==========================================================
  // conversion clock divider
  acc_clk_if ck ();
  acc_pkg::acc_state_t state;
  logic [4:0] halves;

  assign ck.clock_select = conv_clock_select;
  assign ck.run = (state == acc_pkg::ACC_RUN);

  acc_clk_div acc_clk_div_inst (
    .mclk(mclk),
    .rstn(rstn),
    .ck(ck)
  );

  // ==========================================================
  // sequencer: counts 23 half periods, i.e. 11.5 periods
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= acc_pkg::ACC_IDLE;
    end else begin
      case (state)
        acc_pkg::ACC_IDLE: begin
          if (start_req) begin
            state <= acc_pkg::ACC_RUN;
          end
        end
        acc_pkg::ACC_RUN: begin
          if (!converter_enable) begin
            state <= acc_pkg::ACC_IDLE; // disabling aborts
          end else if (ck.half_tick
              && halves == acc_pkg::CONV_HALVES - 5'h01) begin
            state <= acc_pkg::ACC_DONE;
          end
        end
        acc_pkg::ACC_DONE: begin
          state <= acc_pkg::ACC_IDLE;
        end
        default: state <= acc_pkg::ACC_IDLE;
      endcase
    end
  end

  // half period counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      halves <= 5'h00;
    end else if (state != acc_pkg::ACC_RUN) begin
      halves <= 5'h00;
    end else if (ck.half_tick) begin
      halves <= halves + 5'h01;
    end
  end

  // conversion clock level toggles each half period
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conv_clock <= 1'b0;
    end else if (state != acc_pkg::ACC_RUN) begin
      conv_clock <= 1'b0;
    end else if (ck.half_tick) begin
      conv_clock <= !conv_clock;
    end
  end

  // sample-and-hold opens at the same edge the sequence starts and holds during it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= (state == acc_pkg::ACC_RUN)
        || (start_req && state != acc_pkg::ACC_RUN);
    end
  end

  // busy flag
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conv_busy <= 1'b0;
    end else begin
      conv_busy <= (state == acc_pkg::ACC_RUN) || start_req;
    end
  end

  // sticky done: the end of a conversion wins over a status read
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conv_done <= 1'b0;
    end else if (state == acc_pkg::ACC_DONE) begin
      conv_done <= 1'b1;
    end else if (done_clr || start_req) begin
      conv_done <= 1'b0;
    end
  end

  // ==========================================================
  // read data registered at the end of the setup phase
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = acc_pkg::UNMAPPED_READ;
    case (paddr)
      acc_pkg::ADDR_CTRL_FIRST: begin
        next_prdata[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W] = channel_select;
        next_prdata[acc_pkg::START_BIT] = (state == acc_pkg::ACC_RUN);
        next_prdata[acc_pkg::ENABLE_BIT] = converter_enable;
      end
      acc_pkg::ADDR_CTRL_SECOND: begin
        next_prdata[acc_pkg::PREF_LSB +: acc_pkg::PREF_W] = pos_ref_select;
        next_prdata[acc_pkg::NREF_BIT] = neg_ref_ground;
        next_prdata[acc_pkg::CCS_LSB +: acc_pkg::CCS_W] = conv_clock_select;
      end
      acc_pkg::ADDR_STATUS: begin
        next_prdata[acc_pkg::BUSY_BIT] = conv_busy;
        next_prdata[acc_pkg::DONE_BIT] = conv_done;
        next_prdata[acc_pkg::HALF_BIT] = conv_clock;
        next_prdata[acc_pkg::PHASE_LSB +: acc_pkg::PHASE_W] = halves;
      end
      default: next_prdata = acc_pkg::UNMAPPED_READ;
    endcase
  end

  // prdata latched in setup phase so it is stable in the access phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule : acc_adc_ctrl

/* File: core/acc_pkg.sv */
// package: register map, field layout and encodings of the converter control
package acc_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_CTRL_FIRST = 8'h00;
  localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // converter_ctrl_first fields
  localparam int CHAN_LSB = 2;
  localparam int CHAN_W = 6;
  localparam int START_BIT = 1;
  localparam int ENABLE_BIT = 0;
  // converter_ctrl_second fields
  localparam int PREF_LSB = 0;
  localparam int PREF_W = 2;
  localparam int NREF_BIT = 2;
  localparam int CCS_LSB = 4;
  localparam int CCS_W = 3;
  // status fields
  localparam int BUSY_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int HALF_BIT = 2;
  localparam int PHASE_LSB = 8;
  localparam int PHASE_W = 5;
  // reset values
  localparam logic [5:0] CHAN_RESET = 6'h00;
  localparam logic [1:0] PREF_RESET = 2'h0;
  localparam logic [2:0] CCS_RESET = 3'h0;
  // conversion length: 11.5 periods = 23 half periods
  localparam logic [4:0] CONV_HALVES = 5'h17;
  // system clock divide exponent per conv_clock_select code
  localparam logic [2:0] DIVX_2 = 3'h1;
  localparam logic [2:0] DIVX_4 = 3'h2;
  localparam logic [2:0] DIVX_8 = 3'h3;
  localparam logic [2:0] DIVX_16 = 3'h4;
  localparam logic [2:0] DIVX_32 = 3'h5;
  localparam logic [2:0] DIVX_64 = 3'h6;
  localparam logic [2:0] CCS_DIV2 = 3'h0;
  localparam logic [2:0] CCS_DIV4 = 3'h4;
  localparam logic [2:0] CCS_DIV8 = 3'h1;
  localparam logic [2:0] CCS_DIV16 = 3'h5;
  localparam logic [2:0] CCS_DIV32 = 3'h2;
  localparam logic [2:0] CCS_DIV64 = 3'h6;
  localparam logic [1:0] CCS_RC_LOW = 2'h3;
  // dedicated rc clock half period in system clocks (rough model)
  localparam int RC_HALF_NS = 2000;
  localparam int MCLK_NS = 5;
  localparam logic [9:0] RC_HALF_CYC = 10'(RC_HALF_NS / MCLK_NS);
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {ACC_IDLE, ACC_RUN, ACC_DONE} acc_state_t;
endpackage : acc_pkg

/* File: core/acc_clk_if.sv */
// interface: conversion clock select into the divider, half ticks out
`timescale 1ns/1ps
interface acc_clk_if;
  logic [2:0] clock_select;
  logic run;
  logic half_tick;
  modport ctrl (output clock_select, output run, input half_tick);
  modport div (input clock_select, input run, output half_tick);
endinterface : acc_clk_if

/* File: core/acc_clk_div.sv */
// module: conversion clock divider producing half-period enable pulses
`timescale 1ns/1ps
module acc_clk_div (
  input wire logic mclk,
  input wire logic rstn,
  acc_clk_if.div ck
);
  logic [9:0] cnt;
  logic [9:0] half_len;

  // half period length in system clocks from the select code
  always_comb begin
    half_len = 10'h001;
    case (ck.clock_select)
      acc_pkg::CCS_DIV2: half_len = 10'h001 << (acc_pkg::DIVX_2 - 3'h1);
      acc_pkg::CCS_DIV4: half_len = 10'h001 << (acc_pkg::DIVX_4 - 3'h1);
      acc_pkg::CCS_DIV8: half_len = 10'h001 << (acc_pkg::DIVX_8 - 3'h1);
      acc_pkg::CCS_DIV16: half_len = 10'h001 << (acc_pkg::DIVX_16 - 3'h1);
      acc_pkg::CCS_DIV32: half_len = 10'h001 << (acc_pkg::DIVX_32 - 3'h1);
      acc_pkg::CCS_DIV64: half_len = 10'h001 << (acc_pkg::DIVX_64 - 3'h1);
      default: half_len = acc_pkg::RC_HALF_CYC; // x11 rc source
    endcase
  end

  // counter restarts with each conversion so the first period is whole
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 10'h000;
    end else if (!ck.run || cnt + 10'h001 >= half_len) begin
      cnt <= 10'h000;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end

  assign ck.half_tick = ck.run && (cnt + 10'h001 >= half_len);
endmodule : acc_clk_div

/* File: verification/acc_adc_ctrl_monitor.sv */
// checker: port relations of the converter control block
`timescale 1ns/1ps
module acc_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] channel_select,
  input wire logic [1:0] pos_ref_select,
  input wire logic neg_ref_ground,
  input wire logic [2:0] conv_clock_select,
  input wire logic rc_clock_enable,
  input wire logic converter_enable,
  input wire logic sample_hold,
  input wire logic conv_clock,
  input wire logic conv_busy,
  input wire logic conv_done
);
  // ==========================================
  // relations over time
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // completed apb write, pready is tied high
  wire wr = psel && penable && pwrite;
  chk_chan_write: assert property (
    wr && paddr == 8'h00 |=> channel_select == $past(pwdata[7:2]))
    else $error("channel select not taken");
  chk_ref_write: assert property (
    wr && paddr == 8'h04 |=> pos_ref_select == $past(pwdata[1:0])
    && neg_ref_ground == $past(pwdata[2])) else $error("refs not taken");
  chk_ccs_write: assert property (
    wr && paddr == 8'h04 |=> conv_clock_select == $past(pwdata[6:4]))
    else $error("clock select not taken");
  chk_cfg_hold: assert property (
    !(wr && paddr == 8'h04) |=> $stable(pos_ref_select))
    else $error("reference changed without write");
  chk_rc_enable: assert property (
    $stable(conv_clock_select) ##1 $stable(conv_clock_select)
    |-> rc_clock_enable == (conv_clock_select[1:0] == 2'h3))
    else $error("rc enable wrong");
  chk_start_busy: assert property (
    wr && paddr == 8'h00 && pwdata[1:0] == 2'h3 |-> ##[1:2] conv_busy)
    else $error("start not taken");
  chk_done_idle: assert property (
    $rose(conv_done) |-> !conv_busy) else $error("done while busy");
  // shortest divider: 23 half periods of one mclk each
  chk_div2_len: assert property (
    $rose(conv_busy) && conv_clock_select == 3'h0 |-> conv_busy[*8]
    ##1 conv_busy[*8] ##1 conv_busy[*6] ##[1:5] !conv_busy)
    else $error("divide by two length wrong");
  chk_idle_clock: assert property (
    !conv_busy && !$past(conv_busy) |-> !conv_clock)
    else $error("conversion clock runs while idle");
endmodule : acc_monitor

/* File: verification/adc_config_control_tb_top.sv */
// testbench: apb stimulus, conversions per clock code, abort, map
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module adc_config_control_tb_top;
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hb825;
  logic pready, pslverr, er, neg_ref_ground, rc_clock_enable, pc;
  logic converter_enable, sample_hold, conv_clock, conv_busy, conv_done;
  logic [5:0] channel_select;
  logic [1:0] pos_ref_select;
  logic [2:0] conv_clock_select;
  int err_count = 0, checks_done = 0, n, cnt, h, tg;
  // settling wait after a channel change, in system clocks
  localparam int ACQ_CYC = 8;
  // ground source code: arbitrary choice for this bench
  localparam logic [5:0] GND_CHAN = 6'h3f;
  acc_adc_ctrl acc_adc_ctrl_inst (.mclk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_select,
    .pos_ref_select, .neg_ref_ground, .conv_clock_select, .rc_clock_enable,
    .converter_enable, .sample_hold, .conv_clock, .conv_busy, .conv_done);
  // ==========================================
  // clock, watchdog and helpers
  initial forever #2.5 mclk = ~mclk;
  // conversions with the rc clock dominate the run time
  initial begin
    #400000;
    err_count++;
    $display("MISMATCH t=%0t watchdog", $time);
    finish_test();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t no pready", $time);
    end
    psel <= 0;
    penable <= 0;
    // outputs launched at the access edge are looked at once settled
    @(negedge mclk);
  endtask : apb
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1;
    for (int a = 0; a < 12; a += 4) begin
      apb(0, a[7:0], 32'h0);
      `CHK(rd, 32'h0)
    end
    `CHK({channel_select, pos_ref_select, conv_clock_select}, 11'h0)
    apb(0, 8'h0c, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    $display("reset and map test done");
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      apb(1, 8'h04, {25'h0, c[2:0], 1'b0, seed[2:0]});
      apb(0, 8'h04, 32'h0);
      `CHK(rd, {25'h0, c[2:0], 1'b0, seed[2:0]})
      `CHK({conv_clock_select, neg_ref_ground}, {c[2:0], seed[2]})
      `CHK(rc_clock_enable, c[1:0] == 2'h3)
    end
    $display("config test done");
    // every clock code: busy length is 23 half periods
    for (int c = 0; c < 8; c++) begin
      h = (c[1:0] == 2'h3) ? acc_pkg::RC_HALF_CYC : 1 << (c[2] + 2 * c[1:0]);
      seed = lfsr(seed);
      apb(1, 8'h04, {25'h0, c[2:0], 4'h0});
      apb(1, 8'h00, {24'h0, GND_CHAN, 2'b01});
      apb(1, 8'h00, {24'h0, seed[5:0], 2'b01});
      `CHK({channel_select, converter_enable}, {seed[5:0], 1'b1})
      repeat (ACQ_CYC) @(posedge mclk);
      apb(1, 8'h00, {24'h0, seed[5:0], 2'b11});
      n = 0;
      while (conv_busy !== 1'b1 && n < 5) begin @(negedge mclk); n++; end
      `CHK({conv_busy, sample_hold}, 2'b11)
      cnt = 0;
      tg = 0;
      pc = conv_clock;
      // 23 toggles of the conversion clock, then back to its idle low
      while (conv_busy === 1'b1 && cnt < 20000) begin
        @(negedge mclk);
        cnt++;
        tg += (conv_clock !== pc);
        pc = conv_clock;
      end
      `CHK(cnt >= 23 * h && cnt <= 23 * h + 3, 1'b1)
      `CHK(tg, 24)
      `CHK(conv_done, 1'b1)
      apb(0, 8'h08, 32'h0);
      `CHK(rd[1:0], 2'b10)
      apb(0, 8'h08, 32'h0);
      `CHK(rd[1], 1'b0)
    end
    $display("conversion test done");
    // clearing enable mid-run stops without a done
    apb(1, 8'h04, 32'h60);
    apb(1, 8'h00, 32'h3);
    repeat (40) @(posedge mclk);
    apb(1, 8'h00, 32'h0);
    repeat (3) @(posedge mclk);
    `CHK({conv_busy, conv_done, conv_clock}, 3'b000)
    $display("abort test done");
    // reset in mid-run clears sequencer, configuration and outputs at once
    apb(1, 8'h00, 32'h3);
    repeat (20) @(posedge mclk);
    rstn <= 0;
    repeat (2) @(posedge mclk);
    `CHK({conv_busy, sample_hold, conv_clock, conv_clock_select}, 6'h0)
    rstn <= 1;
    apb(0, 8'h08, 32'h0);
    `CHK(rd, 32'h0)
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : adc_config_control_tb_top
bind acc_adc_ctrl acc_monitor acc_monitor_inst (.mclk, .rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .channel_select, .pos_ref_select, .neg_ref_ground, .conv_clock_select,
  .rc_clock_enable, .converter_enable, .sample_hold, .conv_clock,
  .conv_busy, .conv_done);
